//--- rtl/olm_alu.v
// olm_alu.v - byte result and flag logic for or and move
// assumes: purely combinational, same clock domain as caller
`default_nettype none
module olm_alu (
   // operands
   input  wire [7:0] acc,
   input  wire [7:0] opnd,
   input  wire       is_or,
   // results
   output wire [7:0] res,
   output wire       neg,
   output wire       zero
);
   // ==================================================
   // datapath
   assign res  = is_or ? (acc | opnd) : opnd;
   assign neg  = res[7];                        // flags from result
   assign zero = (res == 8'h00);
endmodule // olm_alu
`default_nettype wire

//--- rtl/olm_exec.v
// olm_exec.v - executes or-with-file, move-file and pointer-load words
// assumes: apb master on pclk; instruction words written one at a time
// assumes: reads and writes arrive one at a time, never overlapping
//
// Decided for this implementation: the address map and register access over APB.
`include "olm_map.vh"
`default_nettype none
module olm_exec #(
   parameter MEM_DEPTH = 4096  // data space bytes
) (
   // apb slave
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr
);
   // ==================================================
   // state
   // architectural state of the core slice plus debug visibility
   reg [7:0]  acc_r;                       // working accumulator
   reg [3:0]  bank_select_register_r;      // bank select
   reg [11:0] ptr_r [0:2];                 // indirect pointers
   reg [7:0]  mem_r [0:MEM_DEPTH-1];       // data space
   reg        neg_r, zero_r;               // status flags
   reg        ext_en_r;                    // extended set enable
   reg        wait_lo_r;                   // second pointer word due
   reg [1:0]  sel_r;                       // pending pointer selector
   reg [3:0]  hi_r;                        // pending literal high part
   reg        badop_r, idx_r;              // last word unknown / indexed
   reg [11:0] dbg_addr_r;                  // memory peek address
   reg [7:0]  last_res_r;
   // ==================================================
   // decode of the instruction word
   // an instruction word only counts in the write access phase, the
   // same edge at which the master samples pready high, so a word is
   // never executed twice however long psel stays up
   // field layout: [15:10] opcode, [9] destination, [8] bank, [7:0] file
   wire        acc_w    = psel & penable & pwrite;   // write access phase
   // upper half of pwdata is ignored for instruction words
   wire [15:0] iw       = pwdata[15:0];
   wire        d_bit    = iw[9];
   wire        a_bit    = iw[8];
   wire [7:0]  f_addr   = iw[7:0];
   wire        is_or    = (iw[15:10] == `OLM_OP_OR);
   wire        is_mv    = (iw[15:10] == `OLM_OP_MOVE);
   // selector 3 names no pointer: such a word is refused as unknown
   wire        is_p1    = (iw[15:8] == `OLM_OP_PTR1) & (iw[5:4] != 2'b11);
   wire        is_p2    = (iw[15:8] == `OLM_OP_PTR2);
   // indexed literal offset when access bank, extended, low address
   // limitation: only pointer 2 serves as base; the sum wraps at 12 bits
   wire        use_idx  = ~a_bit & ext_en_r & (f_addr <= `OLM_IDX_LIMIT);
   // ==================================================
   // effective address resolution
   // priority: indexed mode first, since it only exists with a=0;
   // then banked space, then the two halves of the access bank.
   // the upper access half maps onto the top page where special
   // registers would sit in a full core
   function [11:0] eff_addr;
      input       a;
      input       idx;
      input [7:0] f;
      input [3:0] bank;
      input [11:0] p2;
      begin
         if (idx)
            eff_addr = p2 + {4'h0, f};                // indexed from pointer 2
         else if (a)
            eff_addr = {bank, f};                     // banked general purpose
         else if (f[7])
            eff_addr = {4'hf, f};                     // access bank upper half
         else
            eff_addr = {4'h0, f};                     // access bank lower half
      end
   endfunction
   // operand fetch is combinational so read, process and write fit one cycle
   wire [11:0] ea    = eff_addr(a_bit, use_idx, f_addr, bank_select_register_r, ptr_r[2]);
   wire [7:0]  opnd  = mem_r[ea];
   wire [7:0]  res;
   wire        res_n, res_z;
   // shared byte path: or and move differ only in the accumulator term
   olm_alu u_alu (
      .acc  (acc_r),
      .opnd (opnd),
      .is_or(is_or),
      .res  (res),
      .neg  (res_n),
      .zero (res_z)
   );
   // word written to the instruction slot this cycle
   wire is_instr = acc_w & (paddr == `OLM_REG_INSTR);
   // ==================================================
   // execution and register writes
   // one process owns every architectural register but the data space so that an
   // instruction and a direct register write can never both land
   // in one cycle; apb only carries one access at a time anyway.
   // a pending second pointer word takes priority over decode, so
   // the low byte word is never mistaken for another instruction
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // everything but the data space starts cleared
         acc_r                  <= 8'h00;
         bank_select_register_r <= 4'h0;
         ptr_r[0]               <= 12'h000;
         ptr_r[1]               <= 12'h000;
         ptr_r[2]               <= 12'h000;
         neg_r                  <= 1'b0;
         zero_r                 <= 1'b0;
         ext_en_r               <= 1'b0;
         wait_lo_r              <= 1'b0;
         sel_r                  <= 2'h0;
         hi_r                   <= 4'h0;
         badop_r                <= 1'b0;
         idx_r                  <= 1'b0;
         dbg_addr_r             <= 12'h000;
         last_res_r             <= 8'h00;
      end else if (is_instr) begin
         if (wait_lo_r) begin
            // second word: low byte; flags untouched
            wait_lo_r <= 1'b0;
            // a foreign second word aborts; the new high part stays
            badop_r   <= ~is_p2;
            if (is_p2)
               ptr_r[sel_r] <= {hi_r, iw[7:0]};
         end else if (is_or | is_mv) begin
            // single word, single cycle
            // move updates the flags too, even when writing the same value back
            neg_r      <= res_n;
            zero_r     <= res_z;
            idx_r      <= use_idx;
            last_res_r <= res;
            badop_r    <= 1'b0;
            if (!d_bit)
               acc_r <= res;                          // result to accumulator
         end else if (is_p1) begin
            // first word: high part lands in pointer bits 11:8 now
            // selector and high part kept for the low byte word
            wait_lo_r             <= 1'b1;
            sel_r                 <= iw[5:4];
            hi_r                  <= iw[3:0];
            ptr_r[iw[5:4]][11:8]  <= iw[3:0];
            badop_r               <= 1'b0;
         end else
            // any other word leaves the core state alone, only reported
            badop_r <= 1'b1;                          // unsupported word
      end else if (acc_w) begin
         // direct register access; unmapped offsets fall through untouched
         case (paddr)
            `OLM_REG_ACC:      acc_r                  <= pwdata[7:0];
            `OLM_REG_BANK:     bank_select_register_r <= pwdata[3:0];
            `OLM_REG_PTR0:     ptr_r[0]               <= pwdata[11:0];
            `OLM_REG_PTR1:     ptr_r[1]               <= pwdata[11:0];
            `OLM_REG_PTR2:     ptr_r[2]               <= pwdata[11:0];
            `OLM_REG_CTRL:     ext_en_r               <= pwdata[0];
            `OLM_REG_MEM_ADDR: dbg_addr_r             <= pwdata[11:0];
            default:           ;
         endcase
      end
   end
   // ==================================================
   // data memory: file write-back and debug pokes
   // no reset: the data space powers up unknown, as a real file would,
   // and clearing 4096 bytes in one edge would cost a wide reset tree.
   // write-back wins over a debug poke, though apb never issues both
   always @(posedge pclk) begin
      if (is_instr & ~wait_lo_r & (is_or | is_mv) & d_bit)
         mem_r[ea] <= res;                            // result back to file
      // debug poke through the data window
      else if (acc_w & (paddr == `OLM_REG_MEM_DATA))
         mem_r[dbg_addr_r] <= pwdata[7:0];
   end
   // ==================================================
   // apb answer: zero wait states, error on unmapped address
   // read data is chosen during setup from the registers as they stand,
   // so a read that follows a write sees the written value
   // mapped means word aligned and inside the ten word window
   wire mapped = (paddr[1:0] == 2'b00) & (paddr <= `OLM_REG_MEM_DATA);
   // read mux, zero for anything unmapped
   reg [31:0] rd_nxt;
   always @* begin
      rd_nxt = 32'h0000_0000;
      case (paddr)
         `OLM_REG_ACC:      rd_nxt = {24'h0, acc_r};
         `OLM_REG_STATUS:   rd_nxt = {16'h0, last_res_r, 3'h0, idx_r, badop_r, wait_lo_r, neg_r, zero_r};
         `OLM_REG_BANK:     rd_nxt = {28'h0, bank_select_register_r};
         `OLM_REG_PTR0:     rd_nxt = {20'h0, ptr_r[0]};
         `OLM_REG_PTR1:     rd_nxt = {20'h0, ptr_r[1]};
         `OLM_REG_PTR2:     rd_nxt = {20'h0, ptr_r[2]};
         `OLM_REG_CTRL:     rd_nxt = {31'h0, ext_en_r};
         `OLM_REG_MEM_ADDR: rd_nxt = {20'h0, dbg_addr_r};
         `OLM_REG_MEM_DATA: rd_nxt = {24'h0, mem_r[dbg_addr_r]};
         default:           rd_nxt = 32'h0000_0000;
      endcase
   end
   // pready rises as the access phase begins
   // all three answer outputs come from flops and stand for exactly
   // one cycle; outside it prdata is held at zero so that a stale
   // value can never be mistaken for fresh read data
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         // error only alongside ready, so it also stands one cycle
         pslverr <= psel & ~penable & ~mapped;
         // read data only for a read setup
         prdata  <= (psel & ~penable & ~pwrite) ? rd_nxt : 32'h0000_0000;
      end
   end
endmodule // olm_exec
`default_nettype wire

//--- rtl/olm_map.vh
// olm_map.vh - constants for the or/move/pointer-load execution block
// assumes: included by bare name from rtl and tb files
`ifndef OLM_MAP_VH
`define OLM_MAP_VH
// ==================================================
// apb register offsets (byte addresses)
`define OLM_REG_INSTR      12'h000
`define OLM_REG_ACC        12'h004
`define OLM_REG_STATUS     12'h008
`define OLM_REG_BANK       12'h00c
`define OLM_REG_PTR0       12'h010
`define OLM_REG_PTR1       12'h014
`define OLM_REG_PTR2       12'h018
`define OLM_REG_CTRL       12'h01c
`define OLM_REG_MEM_ADDR   12'h020
`define OLM_REG_MEM_DATA   12'h024
// ==================================================
// opcode fields
`define OLM_OP_OR          6'h04
`define OLM_OP_MOVE        6'h14
`define OLM_OP_PTR1        8'hee
`define OLM_OP_PTR2        8'hf0
`define OLM_IDX_LIMIT      8'h5f
// ==================================================
// status bit positions
`define OLM_ST_ZERO        0
`define OLM_ST_NEG         1
`define OLM_ST_BUSY        2
`define OLM_ST_BADOP       3
`define OLM_ST_IDX         4
`endif

//--- tb/olm_exec_monitor.sv
// olm_exec_monitor.sv - port assertions for the or/move/pointer-load block
// assumes: bound to olm_exec; one pclk domain, presetn async low
`include "olm_map.vh"
`default_nettype none
module olm_exec_monitor (
   // apb side
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==================================================
   // helpers: completing reads of status and pointers
   wire st_rd  = pready && !pwrite && paddr == `OLM_REG_STATUS;
   wire ptr_rd = pready && !pwrite && paddr >= `OLM_REG_PTR0 && paddr <= `OLM_REG_PTR2;
   wire mapped = paddr <= `OLM_REG_MEM_DATA && paddr[1:0] == 2'b00;
   a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no answer after setup");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
   a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_idle_data_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
   a_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == 32'h0) else $error("bad address taken");
   a_ok_mapped: assert property (pready && mapped |-> !pslverr) else $error("good address refused");
   a_zero_flag_res: assert property (st_rd && prdata[`OLM_ST_ZERO] |-> prdata[15:8] == 8'h00)
      else $error("zero flag with nonzero result");
   a_neg_flag_res: assert property (st_rd && prdata[`OLM_ST_NEG] |-> prdata[15])
      else $error("neg flag without sign bit");
   a_ptr_twelve_bits: assert property (ptr_rd |-> prdata[31:12] == 20'h0)
      else $error("pointer wider than twelve bits");
   // main scenarios seen
   cover property (st_rd && prdata[`OLM_ST_ZERO]);
   cover property (pslverr);
   cover property (pready && pwrite && paddr == `OLM_REG_INSTR);
endmodule // olm_exec_monitor
bind olm_exec olm_exec_monitor u_olm_exec_monitor (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

//--- tb/or_load_move_instr_exec_bench.sv
// or_load_move_instr_exec_bench.sv - random and corner tests over apb
// assumes: olm_map.vh on the include path; slave answers when it likes
`include "olm_map.vh"
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %0t got %h want %h", $time, g, e); end end
module or_load_move_instr_exec_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // ==================================================
   // stimulus and bookkeeping
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, r, seed = 32'h78509ec8;
   int          n_mismatch = 0, samples_checked = 0, cyc = 0;
   always #5 pclk = ~pclk;
   olm_exec u_olm_exec (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // hang guard, well above the expected run
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         summarize();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // operand address as the block should resolve it
   function automatic logic [11:0] eaddr(logic a, x, logic [7:0] f, logic [3:0] b, logic [11:0] p2);
      if (!a && x && f <= 8'h5f) return p2 + {4'h0, f};
      if (!a) return f[7] ? {4'hf, f} : {4'h0, f};
      return {b, f};
   endfunction
   // one apb transfer, request held until ready is sampled
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one or/move word with random operands
   task automatic run(input logic [5:0] op, input logic d, a, x, input logic [7:0] f, input logic z);
      logic [7:0]  w, m, res;
      logic [11:0] ea;
      r = rnd();
      w = z ? 8'h00 : r[7:0];
      m = z ? 8'h00 : r[15:8];
      ea = eaddr(a, x, f, r[19:16], r[31:20]);
      res = op == `OLM_OP_OR ? w | m : m;
      apb(1'b1, `OLM_REG_BANK, {28'h0, r[19:16]});
      apb(1'b1, `OLM_REG_PTR2, {20'h0, r[31:20]});
      apb(1'b1, `OLM_REG_CTRL, {31'h0, x});
      apb(1'b1, `OLM_REG_MEM_ADDR, {20'h0, ea});
      apb(1'b1, `OLM_REG_MEM_DATA, {24'h0, m});
      apb(1'b1, `OLM_REG_ACC, {24'h0, w});
      apb(1'b1, `OLM_REG_INSTR, {16'h0, op, d, a, f});
      apb(1'b0, `OLM_REG_ACC, 32'h0);
      `CHK(rd[7:0], d ? w : res)
      apb(1'b0, `OLM_REG_MEM_DATA, 32'h0);
      `CHK(rd[7:0], d ? res : m)
      apb(1'b0, `OLM_REG_STATUS, 32'h0);
      `CHK({rd[15:8], rd[4], rd[1:0]}, {res, !a && x && f <= 8'h5f, res[7], res == 8'h00})
   endtask
   // two-word pointer load, flags must not move
   task automatic lpl(input logic [1:0] s, input logic [11:0] k);
      logic [31:0] st;
      apb(1'b0, `OLM_REG_STATUS, 32'h0);
      st = rd;
      apb(1'b1, `OLM_REG_INSTR, {16'h0, 8'hee, 2'b00, s, k[11:8]});
      apb(1'b0, `OLM_REG_PTR0 + {8'h0, s, 2'b00}, 32'h0);
      `CHK(rd[11:8], k[11:8])
      apb(1'b0, `OLM_REG_STATUS, 32'h0);
      `CHK(rd[3:0], {2'b01, st[1:0]})
      apb(1'b1, `OLM_REG_INSTR, {16'h0, 8'hf0, k[7:0]});
      apb(1'b0, `OLM_REG_PTR0 + {8'h0, s, 2'b00}, 32'h0);
      `CHK(rd, {20'h0, k})
      apb(1'b0, `OLM_REG_STATUS, 32'h0);
      `CHK(rd[3:0], {2'b00, st[1:0]})
   endtask
   task automatic summarize();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ==================================================
   // main sequence: reset, refusals, instructions, loads
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OLM_REG_ACC, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, 12'h028, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
      apb(1'b1, 12'h006, 32'h1);
      `CHK(er, 1'b1)
      for (int i = 0; i < 96; i++)
         run(i[0] ? `OLM_OP_MOVE : `OLM_OP_OR, i[1], i[2], i[3], i < 32 ? 8'h5f + {7'h0, i[4]} : rnd(), i[6:4] == 3'd5);
      apb(1'b1, `OLM_REG_INSTR, {16'h0, 8'hee, 2'b00, 2'b11, 4'h5});
      apb(1'b0, `OLM_REG_STATUS, 32'h0);
      `CHK(rd[3:2], 2'b10)
      lpl(2'd0, 12'h000);
      lpl(2'd1, 12'hfff);
      r = rnd();
      lpl(2'd2, r[11:0]);
      summarize();
   end
endmodule // or_load_move_instr_exec_bench
`default_nettype wire
